// [inc/aabx_pkg.sv]
package aabx_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int POS_W = 3;

    // Instruction period and clock period, both in ns
    localparam int TCY_NS = 100;
    localparam int CLK_NS = 100;
    // A taken skip spends this many instruction periods in total
    localparam int SKIP_TCY = 2;
    localparam int SKIP_CYC = SKIP_TCY * TCY_NS / CLK_NS;

    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
    localparam logic FLAG_RST = 1'h0;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
    localparam int NIBBLE_W = 4;

    typedef enum logic [2:0] {
        AABX_ADD_IMMEDIATE = 3'h0,
        AABX_ADD_REGISTER = 3'h1,
        AABX_AND_IMMEDIATE = 3'h2,
        AABX_AND_REGISTER = 3'h3,
        AABX_CLEAR_REGISTER_BIT = 3'h4,
        AABX_SET_REGISTER_BIT = 3'h5,
        AABX_SKIP_IF_BIT_LOW = 3'h6,
        AABX_SKIP_IF_BIT_HIGH = 3'h7
    } aabx_op_t;

    typedef enum logic [1:0] {
        AABX_ST_EXEC = 2'h1,
        AABX_ST_IDLE = 2'h2
    } aabx_state_t;

    typedef enum logic {
        AABX_FN_ADD = 1'h0,
        AABX_FN_AND = 1'h1
    } aabx_fn_t;

    function automatic logic [DATA_W-1:0] bit_mask(input logic [POS_W-1:0] pos);
        bit_mask = ONE_BYTE << pos;
    endfunction

endpackage

// [inc/aabx_alu_if.sv]
`timescale 1ns/1ps
interface aabx_alu_if;
    logic [7:0] a;
    logic [7:0] b;
    aabx_pkg::aabx_fn_t fn;
    logic [7:0] res;
    logic carry;
    logic half_carry;
    logic zero;

    modport main (output a, output b, output fn, input res, input carry, input half_carry,
                  input zero);
    modport alu (input a, input b, input fn, output res, output carry, output half_carry,
                 output zero);
endinterface

// [src/aabx_alu.sv]
`timescale 1ns/1ps
module aabx_alu (
    aabx_alu_if.alu u
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        sum = {1'h0, u.a} + {1'h0, u.b};
        low_sum = {1'h0, u.a[3:0]} + {1'h0, u.b[3:0]};
        if (u.fn == aabx_pkg::AABX_FN_ADD) begin
            u.res = sum[7:0];
        end else begin
            u.res = u.a & u.b;
        end
        u.carry = sum[aabx_pkg::DATA_W]; // see [RL11]
        u.half_carry = low_sum[aabx_pkg::NIBBLE_W]; // see [RL11]
        u.zero = (u.res == aabx_pkg::ZERO_BYTE); // see [RL11]
    end
endmodule

// [src/aabx_exec.sv]
// Behaviour
// [RL1] add_immediate adds immediate_byte to accumulator; updates carry, nibble and zero flags.
// [RL2] add_register adds accumulator and addressed operand_register; updates all three flags.
// [RL3] Register ops write accumulator when result_target_select is 0, register when 1.
// [RL4] and_immediate ANDs accumulator with immediate_byte into accumulator; zero flag only.
// [RL5] and_register ANDs accumulator with register, routed by target select; zero flag only.
// [RL6] clear_register_bit forces selected bit to zero; other bits and flags unchanged.
// [RL7] set_register_bit forces selected bit to one; other bits and flags unchanged.
// [RL8] skip_if_bit_low: bit zero discards next instruction as idle_slot; no flag change.
// [RL9] skip_if_bit_high: bit one discards next instruction as idle_slot; no flag change.
// [RL10] Operands from input/output registers use pin values, not output latches.
// [RL11] Carry from bit 7, nibble carry from bit 3, zero flag when result zero.
`timescale 1ns/1ps
module aabx_exec (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Decoded instruction
    input wire logic instr_valid_i,
    input wire aabx_pkg::aabx_op_t op_i,
    input wire logic [7:0] immediate_byte_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic result_target_select_i,
    input wire logic [2:0] selected_position_i,
    // Operand register contents
    input wire logic [7:0] reg_latch_i,
    input wire logic [7:0] reg_pins_i,
    input wire logic reg_is_io_i,
    // Accumulator and status flags
    output logic [7:0] acc_o,
    output logic unsigned_overflow_flag_o,
    output logic nibble_overflow_flag_o,
    output logic result_null_flag_o,
    // Register write-back
    output logic reg_we_o,
    output logic [6:0] reg_waddr_o,
    output logic [7:0] reg_wdata_o,
    // Skip handling
    output logic idle_slot_o
);
    aabx_alu_if alu_bus ();

    aabx_alu u_alu (
        .u(alu_bus)
    );

    aabx_pkg::aabx_state_t state_ff, nxt_state;
    logic [7:0] acc_ff, nxt_acc;
    logic c_ff, nxt_c;
    logic dc_ff, nxt_dc;
    logic z_ff, nxt_z;
    logic we_ff, nxt_we;
    logic [6:0] waddr_ff, nxt_waddr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic idle_ff, nxt_idle;
    logic take;
    logic [7:0] src;
    logic [7:0] mask;
    logic tested;

    // Writes go straight to the latch, so the pins win only for the source read
    assign src = reg_is_io_i ? reg_pins_i : reg_latch_i; // see [RL10]
    assign mask = aabx_pkg::bit_mask(selected_position_i);
    assign tested = |(src & mask);
    assign take = instr_valid_i && (state_ff == aabx_pkg::AABX_ST_EXEC);

    // Operands apart from next-state logic, so no process both feeds and reads the ALU
    always_comb begin
        alu_bus.a = acc_ff;
        alu_bus.b = src;
        alu_bus.fn = aabx_pkg::AABX_FN_ADD;
        if (op_i == aabx_pkg::AABX_ADD_IMMEDIATE || op_i == aabx_pkg::AABX_AND_IMMEDIATE) begin
            alu_bus.b = immediate_byte_i;
        end
        if (op_i == aabx_pkg::AABX_AND_IMMEDIATE || op_i == aabx_pkg::AABX_AND_REGISTER) begin
            alu_bus.fn = aabx_pkg::AABX_FN_AND;
        end
    end

    always_comb begin
        nxt_state = aabx_pkg::AABX_ST_EXEC;
        nxt_acc = acc_ff;
        nxt_c = c_ff;
        nxt_dc = dc_ff;
        nxt_z = z_ff;
        nxt_we = 1'h0;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        // The instruction in the idle slot is dropped whatever it is
        if (take) begin
            case (op_i)
                aabx_pkg::AABX_ADD_IMMEDIATE: begin
                    nxt_acc = alu_bus.res; // see [RL1]
                    nxt_c = alu_bus.carry;
                    nxt_dc = alu_bus.half_carry;
                    nxt_z = alu_bus.zero;
                end
                aabx_pkg::AABX_ADD_REGISTER, aabx_pkg::AABX_AND_REGISTER: begin
                    if (result_target_select_i) begin
                        nxt_we = 1'h1; // see [RL3]
                        nxt_waddr = reg_addr_i;
                        nxt_wdata = alu_bus.res;
                    end else begin
                        nxt_acc = alu_bus.res; // see [RL3]
                    end
                    nxt_z = alu_bus.zero; // see [RL5]
                    if (op_i == aabx_pkg::AABX_ADD_REGISTER) begin
                        nxt_c = alu_bus.carry; // see [RL2]
                        nxt_dc = alu_bus.half_carry;
                    end
                end
                aabx_pkg::AABX_AND_IMMEDIATE: begin
                    nxt_acc = alu_bus.res; // see [RL4]
                    nxt_z = alu_bus.zero;
                end
                aabx_pkg::AABX_CLEAR_REGISTER_BIT: begin
                    nxt_we = 1'h1;
                    nxt_waddr = reg_addr_i;
                    nxt_wdata = src & ~mask; // see [RL6]
                end
                aabx_pkg::AABX_SET_REGISTER_BIT: begin
                    nxt_we = 1'h1;
                    nxt_waddr = reg_addr_i;
                    nxt_wdata = src | mask; // see [RL7]
                end
                aabx_pkg::AABX_SKIP_IF_BIT_LOW: begin
                    if (!tested) begin
                        nxt_state = aabx_pkg::AABX_ST_IDLE; // see [RL8]
                    end
                end
                aabx_pkg::AABX_SKIP_IF_BIT_HIGH: begin
                    if (tested) begin
                        nxt_state = aabx_pkg::AABX_ST_IDLE; // see [RL9]
                    end
                end
                default: begin
                    nxt_state = aabx_pkg::AABX_ST_EXEC;
                end
            endcase
        end
        nxt_idle = (nxt_state == aabx_pkg::AABX_ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_ff <= aabx_pkg::AABX_ST_EXEC;
            acc_ff <= aabx_pkg::ACC_RST;
            c_ff <= aabx_pkg::FLAG_RST;
            dc_ff <= aabx_pkg::FLAG_RST;
            z_ff <= aabx_pkg::FLAG_RST;
            we_ff <= aabx_pkg::FLAG_RST;
            waddr_ff <= aabx_pkg::ADDR_RST;
            wdata_ff <= aabx_pkg::ZERO_BYTE;
            idle_ff <= aabx_pkg::FLAG_RST;
        end else begin
            state_ff <= nxt_state;
            acc_ff <= nxt_acc;
            c_ff <= nxt_c;
            dc_ff <= nxt_dc;
            z_ff <= nxt_z;
            we_ff <= nxt_we;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            idle_ff <= nxt_idle;
        end
    end

    assign acc_o = acc_ff;
    assign unsigned_overflow_flag_o = c_ff;
    assign nibble_overflow_flag_o = dc_ff;
    assign result_null_flag_o = z_ff;
    assign reg_we_o = we_ff;
    assign reg_waddr_o = waddr_ff;
    assign reg_wdata_o = wdata_ff;
    assign idle_slot_o = idle_ff;

    // Helper sums for the checks below
    logic [8:0] chk_sum;
    logic [4:0] chk_low;
    logic [7:0] chk_b;
    assign chk_b = (op_i == aabx_pkg::AABX_ADD_IMMEDIATE) ? immediate_byte_i : src;
    assign chk_sum = {1'h0, acc_ff} + {1'h0, chk_b};
    assign chk_low = {1'h0, acc_ff[3:0]} + {1'h0, chk_b[3:0]};

    property p_add_imm;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && op_i == aabx_pkg::AABX_ADD_IMMEDIATE
            |=> acc_o == $past(chk_sum[7:0]) && unsigned_overflow_flag_o == $past(chk_sum[8]);
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add_immediate result wrong"); // see [RL1]

    property p_add_reg;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && op_i == aabx_pkg::AABX_ADD_REGISTER && !result_target_select_i
            |=> acc_o == $past(chk_sum[7:0])
                && result_null_flag_o == ($past(chk_sum[7:0]) == 8'h00);
    endproperty
    a_add_reg: assert property (p_add_reg) else $error("add_register result wrong"); // see [RL2]

    property p_dest;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && result_target_select_i
            && (op_i == aabx_pkg::AABX_ADD_REGISTER || op_i == aabx_pkg::AABX_AND_REGISTER)
            |=> reg_we_o && reg_waddr_o == $past(reg_addr_i) && $stable(acc_o);
    endproperty
    a_dest: assert property (p_dest) else $error("register destination not written"); // see [RL3]

    property p_and_imm;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && op_i == aabx_pkg::AABX_AND_IMMEDIATE
            |=> acc_o == $past(acc_ff & immediate_byte_i) && $stable(unsigned_overflow_flag_o)
                && $stable(nibble_overflow_flag_o);
    endproperty
    a_and_imm: assert property (p_and_imm) else $error("and_immediate wrong"); // see [RL4]

    property p_and_reg;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && op_i == aabx_pkg::AABX_AND_REGISTER
            |=> result_null_flag_o == ($past(acc_ff & src) == 8'h00)
                && $stable(unsigned_overflow_flag_o);
    endproperty
    a_and_reg: assert property (p_and_reg) else $error("and_register wrong"); // see [RL5]

    property p_bit_op;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && (op_i == aabx_pkg::AABX_CLEAR_REGISTER_BIT
            || op_i == aabx_pkg::AABX_SET_REGISTER_BIT)
            |=> reg_we_o && reg_wdata_o[$past(selected_position_i)] == $past(op_i[0])
                && $stable(result_null_flag_o) && $stable(unsigned_overflow_flag_o);
    endproperty
    a_bit_op: assert property (p_bit_op) else $error("bit clear or set wrong"); // see [RL6] [RL7]

    property p_skip_low;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && op_i == aabx_pkg::AABX_SKIP_IF_BIT_LOW && !tested
            |=> idle_slot_o && $stable(acc_o) ##1 !idle_slot_o && !reg_we_o;
    endproperty
    a_skip_low: assert property (p_skip_low) else $error("skip_if_bit_low wrong"); // see [RL8]

    property p_skip_high;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && op_i == aabx_pkg::AABX_SKIP_IF_BIT_HIGH
            |=> idle_slot_o == $past(tested) && $stable(result_null_flag_o);
    endproperty
    a_skip_high: assert property (p_skip_high) else $error("skip_if_bit_high wrong"); // see [RL9]

    property p_io_src;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && reg_is_io_i && op_i == aabx_pkg::AABX_SET_REGISTER_BIT
            |=> reg_wdata_o == $past(reg_pins_i | mask);
    endproperty
    a_io_src: assert property (p_io_src) else $error("pin value not used as source"); // see [RL10]

    property p_half;
        @(posedge clk_i) disable iff (!arst_n_i)
        take && op_i == aabx_pkg::AABX_ADD_IMMEDIATE |=> nibble_overflow_flag_o == $past(chk_low[4]);
    endproperty
    a_half: assert property (p_half) else $error("nibble carry wrong"); // see [RL11]

    c_skip: cover property (@(posedge clk_i) disable iff (!arst_n_i) take ##1 idle_slot_o);
    c_carry: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        $rose(unsigned_overflow_flag_o) && nibble_overflow_flag_o);
    c_write: cover property (@(posedge clk_i) disable iff (!arst_n_i) reg_we_o ##1 reg_we_o);
endmodule

// [dv/aabx_exec_test.sv]
`timescale 1ns/1ps
module aabx_exec_test;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic instr_valid_i = 1'b0;
    aabx_pkg::aabx_op_t op_i = aabx_pkg::AABX_ADD_IMMEDIATE;
    logic [7:0] immediate_byte_i = 8'h00;
    logic [6:0] reg_addr_i = 7'h00;
    logic result_target_select_i = 1'b0;
    logic [2:0] selected_position_i = 3'h0;
    logic [7:0] reg_latch_i = 8'h00;
    logic [7:0] reg_pins_i = 8'h00;
    logic reg_is_io_i = 1'b0;
    logic [7:0] acc_o;
    logic unsigned_overflow_flag_o;
    logic nibble_overflow_flag_o;
    logic result_null_flag_o;
    logic reg_we_o;
    logic [6:0] reg_waddr_o;
    logic [7:0] reg_wdata_o;
    logic idle_slot_o;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] m_acc = 8'h00;
    logic [7:0] m_wdata = 8'h00;
    logic [6:0] m_waddr = 7'h00;
    logic m_c = 1'b0;
    logic m_dc = 1'b0;
    logic m_z = 1'b0;
    logic m_we = 1'b0;
    logic m_idle = 1'b0;

    aabx_exec dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
        .op_i(op_i), .immediate_byte_i(immediate_byte_i), .reg_addr_i(reg_addr_i),
        .result_target_select_i(result_target_select_i),
        .selected_position_i(selected_position_i), .reg_latch_i(reg_latch_i),
        .reg_pins_i(reg_pins_i), .reg_is_io_i(reg_is_io_i), .acc_o(acc_o),
        .unsigned_overflow_flag_o(unsigned_overflow_flag_o),
        .nibble_overflow_flag_o(nibble_overflow_flag_o),
        .result_null_flag_o(result_null_flag_o), .reg_we_o(reg_we_o),
        .reg_waddr_o(reg_waddr_o), .reg_wdata_o(reg_wdata_o), .idle_slot_o(idle_slot_o));

    always #50 clk_i = ~clk_i;

    task automatic final_report();
        $display("checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 2030 cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            $display("ERROR at %0t: run did not finish", $time);
            final_report();
        end
    end

    task automatic check_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input string what, input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic check_all();
        check_byte("acc", acc_o, m_acc);
        check_bit("carry", unsigned_overflow_flag_o, m_c);
        check_bit("nibble", nibble_overflow_flag_o, m_dc);
        check_bit("zero", result_null_flag_o, m_z);
        check_bit("write", reg_we_o, m_we);
        check_byte("waddr", {1'b0, reg_waddr_o}, {1'b0, m_waddr});
        check_byte("wdata", reg_wdata_o, m_wdata);
        check_bit("idle", idle_slot_o, m_idle);
    endtask

    // Expected sum or AND, with the carry out in the top bit
    function automatic logic [8:0] exp_alu(input logic is_and, input logic [7:0] a,
        input logic [7:0] b);
        exp_alu = is_and ? {1'b0, a & b} : {1'b0, a} + {1'b0, b};
    endfunction

    // Expected carry out of the low nibble
    function automatic logic exp_half(input logic [7:0] a, input logic [7:0] b);
        exp_half = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    endfunction

    // Drives one cycle of inputs, steps the model, checks after the taking edge
    task automatic issue(input logic v, input logic [2:0] op, input logic [7:0] imm,
        input logic [6:0] addr, input logic rts, input logic [2:0] pos,
        input logic [7:0] lat, input logic [7:0] pin, input logic io);
        logic [7:0] src;
        logic [7:0] b;
        logic [8:0] res;
        logic [7:0] mask;
        logic skip;
        instr_valid_i = v;
        op_i = aabx_pkg::aabx_op_t'(op);
        immediate_byte_i = imm;
        reg_addr_i = addr;
        result_target_select_i = rts;
        selected_position_i = pos;
        reg_latch_i = lat;
        reg_pins_i = pin;
        reg_is_io_i = io;
        src = io ? pin : lat;
        b = (op[0] == 1'b0) ? imm : src;
        mask = 8'h01 << pos;
        skip = 1'b0;
        m_we = 1'b0;
        if (v && !m_idle) begin
            if (op[2] == 1'b0) begin
                res = exp_alu(op[1], m_acc, b);
                if (!op[1]) begin
                    m_c = res[8];
                    m_dc = exp_half(m_acc, b);
                end
                m_z = (res[7:0] == 8'h00);
                if (op[0] && rts) begin
                    m_we = 1'b1;
                    m_waddr = addr;
                    m_wdata = res[7:0];
                end else begin
                    m_acc = res[7:0];
                end
            end else if (op[1] == 1'b0) begin
                m_we = 1'b1;
                m_waddr = addr;
                m_wdata = op[0] ? (src | mask) : (src & ~mask);
            end else begin
                skip = op[0] ? src[pos] : !src[pos];
            end
        end
        m_idle = skip;
        @(posedge clk_i);
        #1;
        check_all();
    endtask

    initial begin
        void'($urandom(60));
        repeat (16) @(posedge clk_i);
        #1;
        check_all();
        arst_n_i = 1'b1;
        $display("test reset done");
        issue(1, 3'h2, 8'h00, 7'h00, 0, 3'h0, 8'h00, 8'h00, 0);
        issue(1, 3'h0, 8'hFF, 7'h00, 0, 3'h0, 8'h00, 8'h00, 0);
        issue(1, 3'h0, 8'h01, 7'h00, 0, 3'h0, 8'h00, 8'h00, 0);
        issue(1, 3'h2, 8'hFF, 7'h00, 0, 3'h0, 8'h00, 8'h00, 0);
        issue(1, 3'h0, 8'h01, 7'h00, 0, 3'h0, 8'h00, 8'h00, 0);
        issue(1, 3'h0, 8'h0F, 7'h00, 0, 3'h0, 8'h00, 8'h00, 0);
        issue(1, 3'h1, 8'h00, 7'h7F, 1, 3'h0, 8'hF0, 8'h0F, 1);
        issue(1, 3'h3, 8'h00, 7'h01, 0, 3'h0, 8'hFF, 8'h00, 1);
        issue(1, 3'h5, 8'h00, 7'h05, 0, 3'h7, 8'h00, 8'h00, 0);
        issue(1, 3'h4, 8'h00, 7'h06, 1, 3'h0, 8'hFF, 8'h00, 0);
        issue(1, 3'h6, 8'h00, 7'h02, 0, 3'h3, 8'hFF, 8'hF7, 1);
        issue(1, 3'h0, 8'h55, 7'h00, 0, 3'h0, 8'h00, 8'h00, 0);
        issue(1, 3'h7, 8'h00, 7'h02, 0, 3'h7, 8'h80, 8'h00, 0);
        issue(1, 3'h5, 8'h00, 7'h03, 0, 3'h1, 8'h00, 8'h00, 0);
        issue(1, 3'h7, 8'h00, 7'h02, 0, 3'h0, 8'hFE, 8'h01, 0);
        issue(1, 3'h6, 8'h00, 7'h02, 0, 3'h0, 8'h01, 8'h00, 0);
        $display("test corners done");
        repeat (2000) begin
            issue(($urandom % 8) != 0, 3'($urandom), 8'($urandom), 7'($urandom),
                1'($urandom), 3'($urandom), 8'($urandom), 8'($urandom),
                1'($urandom));
        end
        $display("test random done");
        final_report();
    end
endmodule
